// file: pkg/eac_consts.svh
`ifndef EAC_CONSTS_SVH
`define EAC_CONSTS_SVH

// I/O space offsets
`define EAC_OFS_CONTROL 6'h1c
`define EAC_OFS_DATA 6'h1d
`define EAC_OFS_ADDR_LO 6'h1e
`define EAC_OFS_ADDR_HI 6'h1f

// Control field positions
`define EAC_BIT_READ 0
`define EAC_BIT_WRITE 1
`define EAC_BIT_ARM 2

// Reset values
`define EAC_RST_BYTE 8'h00

// Timing
`define EAC_CLK_NS 20
`define EAC_PROG_TIME_NS 2500000
`define EAC_PROG_CYCLES (`EAC_PROG_TIME_NS / `EAC_CLK_NS)
`define EAC_ARM_CYCLES 3'h4
`define EAC_WRITE_STALL 3'h2
`define EAC_READ_STALL 3'h4

`endif

// file: pkg/eac_pkg.sv
package eac_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } eac_io_req_t;

  typedef enum logic {
    EAC_IDLE,
    EAC_PROG
  } eac_state_t;

endpackage

// file: sim/eac_cpu_model.sv
`timescale 1ns/1ns
module eac_cpu_model
  import eac_pkg::*;
(
  // Clock
  input wire logic clk,
  // Register port
  output eac_io_req_t io_req,
  input wire logic [7:0] io_rdata_q,
  input wire logic cpu_stall_q
);
  int stalls;
  initial io_req = '0;
  // One access, then the halt is waited out before the next
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d,
      output logic [7:0] q);
    @(negedge clk);
    io_req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clk);
    io_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    q = io_rdata_q;
    stalls = 0;
    while (cpu_stall_q === 1'b1 && stalls < 16) begin
      stalls++;
      @(negedge clk);
    end
  endtask
endmodule

// file: sim/testbench.sv
`timescale 1ns/1ns
`include "eac_consts.svh"
module testbench;
  localparam int PROG = 8;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  eac_pkg::eac_io_req_t io_req;
  logic [7:0] io_rdata_q;
  logic cpu_stall_q;
  logic [7:0] q;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #10 clk = ~clk;
  eac_eeprom_ctrl #(.PROG_CYCLES(PROG)) eac_eeprom_ctrl_inst (.clk(clk), .reset_n(reset_n),
    .io_req(io_req), .io_rdata_q(io_rdata_q), .cpu_stall_q(cpu_stall_q));
  eac_cpu_model eac_cpu_model_inst (.clk(clk), .io_req(io_req), .io_rdata_q(io_rdata_q),
    .cpu_stall_q(cpu_stall_q));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    eac_cpu_model_inst.acc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    eac_cpu_model_inst.acc(1'b0, a, 8'h00, q);
    check(q, e);
  endtask
  // Arm then strobe back to back, nothing in between
  task automatic launch();
    wr(`EAC_OFS_CONTROL, 8'h04);
    wr(`EAC_OFS_CONTROL, 8'h02);
    check(8'(eac_cpu_model_inst.stalls), 8'h02);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles > 2000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    for (int i = 28; i < 32; i++) begin
      rd(6'(i), 8'h00);
    end
    wr(`EAC_OFS_ADDR_HI, 8'hff);
    rd(`EAC_OFS_ADDR_HI, 8'h01);
    wr(`EAC_OFS_CONTROL, 8'hfa);
    rd(`EAC_OFS_CONTROL, 8'h00);
    wr(`EAC_OFS_CONTROL, 8'h06);
    rd(`EAC_OFS_CONTROL, 8'h00);
    wr(`EAC_OFS_ADDR_LO, 8'ha5);
    wr(`EAC_OFS_DATA, 8'h5a);
    launch();
    rd(`EAC_OFS_CONTROL, 8'h02);
    repeat (PROG) @(negedge clk);
    rd(`EAC_OFS_CONTROL, 8'h00);
    wr(`EAC_OFS_DATA, 8'h00);
    wr(`EAC_OFS_CONTROL, 8'h01);
    check(8'(eac_cpu_model_inst.stalls), 8'h04);
    rd(`EAC_OFS_DATA, 8'h5a);
    rd(`EAC_OFS_CONTROL, 8'h00);
    wr(`EAC_OFS_CONTROL, 8'h04);
    rd(`EAC_OFS_CONTROL, 8'h04);
    repeat (4) @(negedge clk);
    wr(`EAC_OFS_CONTROL, 8'h02);
    rd(`EAC_OFS_CONTROL, 8'h00);
    wr(`EAC_OFS_DATA, 8'h33);
    launch();
    wr(`EAC_OFS_DATA, 8'h77);
    rd(`EAC_OFS_CONTROL, 8'h00);
    wr(`EAC_OFS_CONTROL, 8'h01);
    rd(`EAC_OFS_DATA, 8'h5a);
    wr(`EAC_OFS_DATA, 8'hc3);
    wr(`EAC_OFS_CONTROL, 8'h04);
    wr(`EAC_OFS_CONTROL, 8'h03);
    check(8'(eac_cpu_model_inst.stalls), 8'h02);
    wr(`EAC_OFS_CONTROL, 8'h04);
    wr(`EAC_OFS_CONTROL, 8'h02);
    check(8'(eac_cpu_model_inst.stalls), 8'h00);
    rd(`EAC_OFS_DATA, 8'hc3);
    repeat (PROG) @(negedge clk);
    wr(`EAC_OFS_CONTROL, 8'h01);
    rd(`EAC_OFS_DATA, 8'hc3);
    wr(`EAC_OFS_CONTROL, 8'h04);
    @(negedge clk);
    reset_n = 1'b0;
    @(negedge clk);
    reset_n = 1'b1;
    rd(`EAC_OFS_CONTROL, 8'h00);
    rd(`EAC_OFS_ADDR_HI, 8'h00);
    conclude();
  end
endmodule

// file: src/eac_eeprom_ctrl.sv
`timescale 1ns/1ns
`include "eac_consts.svh"
// Summary of operation
// - Nine-bit address from high bit0 and low
// - Data register feeds writes, receives reads
// - Control bits 7..3 read zero, ignore writes
// - Write starts only while arm bit set
// - Arm bit self-clears four cycles later
// - Control bit 1 strobes data into EEPROM
// - Write strobe stays set for programming period
// - Write launch stalls processor two cycles
// - Read strobe fetches byte, clears immediately
// - Read launch stalls processor four cycles
// - Arming accepted only with strobe written zero
// - Address or data write aborts active write
module eac_eeprom_ctrl
  import eac_pkg::*;
#(
  parameter int PROG_CYCLES = `EAC_PROG_CYCLES,
  parameter int DEPTH = 512
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // I/O register port
  input eac_io_req_t io_req,
  output logic [7:0] io_rdata_q,
  // Processor halt
  output logic cpu_stall_q
);

  localparam int PCW = $clog2(PROG_CYCLES + 1);

  if (PROG_CYCLES < 1 || DEPTH != 512) begin : g_bad_params
    $error("eac_eeprom_ctrl: unsupported parameters");
  end

  logic [7:0] mem [DEPTH];
  logic [7:0] addr_lo_q;
  logic addr_hi_q;
  logic [7:0] data_q;
  logic arm_q;
  logic [2:0] arm_cnt_q;
  logic wstrobe_q;
  eac_state_t state_q;
  logic [PCW-1:0] prog_cnt_q;
  logic [2:0] stall_cnt_q;

  logic [8:0] nv_address;
  logic wr_ctrl;
  logic wr_data;
  logic wr_lo;
  logic wr_hi;
  logic arm_set;
  logic wr_launch;
  logic rd_launch;
  logic abort;
  logic prog_done;
  logic [7:0] mem_rd_val;

  assign nv_address = {addr_hi_q, addr_lo_q};
  assign mem_rd_val = mem[nv_address];
  assign wr_ctrl = io_req.wr && io_req.addr == `EAC_OFS_CONTROL;
  assign wr_data = io_req.wr && io_req.addr == `EAC_OFS_DATA;
  assign wr_lo = io_req.wr && io_req.addr == `EAC_OFS_ADDR_LO;
  assign wr_hi = io_req.wr && io_req.addr == `EAC_OFS_ADDR_HI;
  // Arming needs the strobe bit written as zero
  assign arm_set = wr_ctrl && io_req.wdata[`EAC_BIT_ARM]
                   && !io_req.wdata[`EAC_BIT_WRITE];
  // Strobe honoured only while armed and idle
  assign wr_launch = wr_ctrl && io_req.wdata[`EAC_BIT_WRITE]
                     && arm_q && state_q == EAC_IDLE;
  assign rd_launch = wr_ctrl && io_req.wdata[`EAC_BIT_READ]
                     && !wr_launch;
  assign abort = state_q == EAC_PROG && (wr_data || wr_lo || wr_hi);
  assign prog_done = state_q == EAC_PROG && prog_cnt_q == PCW'(1);

  // Address registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      addr_lo_q <= `EAC_RST_BYTE;
      addr_hi_q <= 1'b0;
    end else begin
      if (wr_lo) begin
        addr_lo_q <= io_req.wdata;
      end
      if (wr_hi) begin
        addr_hi_q <= io_req.wdata[0];
      end
    end
  end

  // Data register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      data_q <= `EAC_RST_BYTE;
    end else if (rd_launch) begin
      data_q <= mem_rd_val;
    end else if (wr_data) begin
      data_q <= io_req.wdata;
    end
  end

  // Arm bit with four-cycle timeout; a new set wins over the timeout
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      arm_q <= 1'b0;
      arm_cnt_q <= 3'h0;
    end else if (arm_set) begin
      arm_q <= 1'b1;
      arm_cnt_q <= `EAC_ARM_CYCLES - 3'h1;
    end else if (arm_q) begin
      if (arm_cnt_q == 3'h0) begin
        arm_q <= 1'b0;
      end else begin
        arm_cnt_q <= arm_cnt_q - 3'h1;
      end
    end
  end

  // Self-timed programming sequence
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= EAC_IDLE;
      wstrobe_q <= 1'b0;
      prog_cnt_q <= '0;
    end else begin
      unique case (state_q)
        EAC_IDLE: begin
          if (wr_launch) begin
            state_q <= EAC_PROG;
            wstrobe_q <= 1'b1;
            prog_cnt_q <= PCW'(PROG_CYCLES);
          end
        end
        EAC_PROG: begin
          if (abort || prog_done) begin
            state_q <= EAC_IDLE;
            wstrobe_q <= 1'b0;
            prog_cnt_q <= '0;
          end else begin
            prog_cnt_q <= prog_cnt_q - PCW'(1);
          end
        end
      endcase
    end
  end

  // Array update at the end of the period
  always_ff @(posedge clk) begin
    if (prog_done && !abort) begin
      mem[nv_address] <= data_q;
    end
  end

  // Processor halt after each launch
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stall_cnt_q <= 3'h0;
      cpu_stall_q <= 1'b0;
    end else if (wr_launch) begin
      stall_cnt_q <= `EAC_WRITE_STALL;
      cpu_stall_q <= 1'b1;
    end else if (rd_launch) begin
      stall_cnt_q <= `EAC_READ_STALL;
      cpu_stall_q <= 1'b1;
    end else begin
      if (stall_cnt_q != 3'h0) begin
        stall_cnt_q <= stall_cnt_q - 3'h1;
      end
      cpu_stall_q <= stall_cnt_q > 3'h1;
    end
  end

  // Register read port, one cycle latency
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      io_rdata_q <= `EAC_RST_BYTE;
    end else if (io_req.rd) begin
      unique case (io_req.addr)
        `EAC_OFS_CONTROL: io_rdata_q <= {5'h00, arm_q, wstrobe_q, 1'b0};
        `EAC_OFS_DATA: io_rdata_q <= data_q;
        `EAC_OFS_ADDR_LO: io_rdata_q <= addr_lo_q;
        `EAC_OFS_ADDR_HI: io_rdata_q <= {7'h00, addr_hi_q};
        default: io_rdata_q <= `EAC_RST_BYTE;
      endcase
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_quiet4;
    (!arm_set)[*4];
  endsequence

  sequence s_wstall;
    cpu_stall_q[*2] ##1 !cpu_stall_q;
  endsequence

  sequence s_rstall;
    cpu_stall_q[*4] ##1 !cpu_stall_q;
  endsequence

  sequence s_strobe_armed;
    wr_ctrl && io_req.wdata[`EAC_BIT_WRITE] && arm_q && state_q == EAC_IDLE;
  endsequence

  sequence s_prog_start;
    wstrobe_q && cpu_stall_q;
  endsequence

  // Length of the running programming period
  logic [PCW-1:0] strobe_len_q;

  always_ff @(posedge clk) begin
    if (!reset_n || !wstrobe_q) begin
      strobe_len_q <= '0;
    end else begin
      strobe_len_q <= strobe_len_q + PCW'(1);
    end
  end

  chk_arm_hold: assert property (arm_set |=> arm_q[*4])
    else $error("arm bit dropped early");
  chk_arm_timeout: assert property (arm_set ##1 s_quiet4 |=> !arm_q)
    else $error("arm bit did not time out");
  chk_arm_clean: assert property (
    wr_ctrl && io_req.wdata[`EAC_BIT_WRITE] && !arm_q |=> !wstrobe_q || $past(wstrobe_q))
    else $error("write started without arming");
  chk_write_stall: assert property (wr_launch |=> s_wstall)
    else $error("write stall not two cycles");
  chk_read_stall: assert property (rd_launch |=> s_rstall)
    else $error("read stall not four cycles");
  chk_strobe_hold: assert property (wr_launch |=> wstrobe_q && state_q == EAC_PROG)
    else $error("strobe not held during programming");
  chk_strobe_end: assert property (prog_done |=> !wstrobe_q)
    else $error("strobe not cleared after period");
  chk_write_abort: assert property (abort |=> state_q == EAC_IDLE && !wstrobe_q)
    else $error("write not aborted");
  chk_read_data: assert property (rd_launch |=> data_q == $past(mem_rd_val))
    else $error("read byte not loaded");
  chk_ctrl_rsvd: assert property (
    io_req.rd && io_req.addr == `EAC_OFS_CONTROL |=> io_rdata_q[7:3] == 5'h00
    && io_rdata_q[0] == 1'b0)
    else $error("control reserved bits not zero");
  chk_addr_hi: assert property (
    io_req.rd && io_req.addr == `EAC_OFS_ADDR_HI |=> io_rdata_q[7:1] == 7'h00)
    else $error("high address reserved bits not zero");

  chk_armed_launch: assert property (s_strobe_armed |=> s_prog_start)
    else $error("armed strobe did not start a write");
  chk_launch_armed: assert property ($rose(wstrobe_q) |-> $past(arm_q))
    else $error("write launched while not armed");
  chk_arm_refuse: assert property (
    wr_ctrl && io_req.wdata[`EAC_BIT_ARM] && io_req.wdata[`EAC_BIT_WRITE]
    && !arm_q |=> !arm_q)
    else $error("arming taken with strobe bit set");
  chk_arm_window: assert property (arm_q |-> arm_cnt_q < `EAC_ARM_CYCLES)
    else $error("arm countdown out of range");
  chk_arm_kept: assert property (
    wr_launch |=> arm_q || $past(arm_cnt_q) == 3'h0)
    else $error("arm bit consumed by launch");

  chk_strobe_bound: assert property (
    wstrobe_q |-> strobe_len_q < PCW'(PROG_CYCLES))
    else $error("strobe outlasted programming period");
  chk_strobe_full: assert property (
    $fell(wstrobe_q) && $past(reset_n) && !$past(abort)
    |-> strobe_len_q == PCW'(PROG_CYCLES))
    else $error("strobe dropped before period end");
  chk_idle_strobe: assert property (state_q == EAC_IDLE |-> !wstrobe_q)
    else $error("strobe set while idle");
  chk_prog_count: assert property (
    state_q == EAC_PROG |-> prog_cnt_q != '0 && prog_cnt_q <= PCW'(PROG_CYCLES))
    else $error("programming counter out of range");
  chk_read_only: assert property (
    rd_launch && state_q == EAC_IDLE |=> !wstrobe_q)
    else $error("read started a write");
  chk_array_write: assert property (
    prog_done && !abort |=> mem[$past(nv_address)] == $past(data_q))
    else $error("array not updated at end of period");

  chk_stall_cause: assert property (
    $rose(cpu_stall_q) |-> $past(wr_launch || rd_launch))
    else $error("stall without a launch");
  chk_stall_range: assert property (stall_cnt_q <= `EAC_READ_STALL)
    else $error("stall counter out of range");

  chk_data_load: assert property (wr_data |=> data_q == $past(io_req.wdata))
    else $error("data register not loaded");
  chk_write_wins: assert property (wr_launch |=> data_q == $past(data_q))
    else $error("read taken alongside a write launch");
  chk_data_read: assert property (
    io_req.rd && io_req.addr == `EAC_OFS_DATA |=> io_rdata_q == $past(data_q))
    else $error("data register read back wrong");
  chk_ctrl_flags: assert property (
    io_req.rd && io_req.addr == `EAC_OFS_CONTROL
    |=> io_rdata_q[2:1] == $past({arm_q, wstrobe_q}))
    else $error("control flags read back wrong");
  chk_addr_low: assert property (wr_lo |=> addr_lo_q == $past(io_req.wdata))
    else $error("low address not loaded");
  chk_addr_bit8: assert property (wr_hi |=> addr_hi_q == $past(io_req.wdata[0]))
    else $error("address bit 8 not loaded");

endmodule
